// *** verilog/bfr_rescaler_end.sv ***
`default_nettype none
module bfr_rescaler_end (
   input  wire logic                              clk,
   input  wire logic                              nrst,
   bfr_link_if.rescaler                           link,
   output logic                                   full_valid,
   output logic                                   full_sop,
   output logic                                   full_eop,
   output logic [bfr_pkg::FULL_W-1:0]             full_re,
   output logic [bfr_pkg::FULL_W-1:0]             full_im,
   output logic [bfr_pkg::DATA_W-1:0]             sat_re,
   output logic [bfr_pkg::DATA_W-1:0]             sat_im,
   output logic                                   exp_err
);
   // --------------------------------------------------------------
   // exponent span of this engine
   // --------------------------------------------------------------
   // fixed at elaboration, no logic behind these
   // span from length
   localparam int LO = bfr_pkg::bfr_exp_lo(bfr_pkg::LOG2_N, bfr_pkg::QUAD_ENGINE);
   localparam int HI = bfr_pkg::bfr_exp_hi(bfr_pkg::LOG2_N, bfr_pkg::QUAD_ENGINE);

   localparam int FW = bfr_pkg::FULL_W;
   localparam int DW = bfr_pkg::DATA_W;

   // clip limits for the kept low bits
   localparam logic [DW-1:0] SAT_POS = {1'b0, {(DW-1){1'b1}}};
   localparam logic [DW-1:0] SAT_NEG = {1'b1, {(DW-1){1'b0}}};

   // placement map: sample lsb at the left shift count
   //   left shift count is minus the exponent
   //   exponent -11 : bits 26..11, no sign copies
   //   exponent -10 : bits 25..10, one sign copy
   //   exponent  -9 : bits 24..9, two sign copies
   //   exponent  -8 : bits 23..8, three sign copies
   //   exponent  -7 : bits 22..7, four sign copies
   //   exponent  -6 : bits 21..6, five sign copies
   //   exponent  -5 : bits 20..5, six sign copies
   //   exponent  -4 : bits 19..4, seven sign copies
   //   exponent  -3 : bits 18..3, eight sign copies
   //   any other    : bits 15..0, flagged on exp_err

   // --------------------------------------------------------------
   // helpers
   // --------------------------------------------------------------
   // sign extend first, then shift, so zeros enter from below
   // shift is a plain int, only 0 to 11 ever reach it
   // place with sign extension
   function automatic logic [FW-1:0] bfr_place(input logic [DW-1:0] d, input int sh);
      logic signed [FW-1:0] ext;
      ext = FW'(signed'(d));
      return FW'(ext <<< sh);
   endfunction

   // every bit from the kept sign bit up must agree, else clip
   // clip to low bits without wrap
   function automatic logic [DW-1:0] bfr_sat(input logic [FW-1:0] v);
      logic all_zero;
      logic all_one;
      all_zero = (v[FW-1:DW-1] == '0);
      all_one  = (v[FW-1:DW-1] == '1);
      if (all_zero || all_one)
         return v[DW-1:0];
      if (v[FW-1])
         return SAT_NEG;
      return SAT_POS;
   endfunction

   // --------------------------------------------------------------
   // exponent decode
   // --------------------------------------------------------------
   int   lsh;
   logic in_range;

   always_comb begin
      in_range = (int'(link.expo) >= LO) && (int'(link.expo) <= HI);
   end

   // int math, so negating the most negative code cannot overflow
   // out of span codes get no shift; the flag tells downstream
   // minus exponent, left shifts
   always_comb begin
      lsh = -int'(link.expo) - (-LO - bfr_pkg::MAX_LSHIFT);
      if (!in_range)
         lsh = 0;
   end

   // --------------------------------------------------------------
   // placement and clipping
   // --------------------------------------------------------------
   logic [FW-1:0] next_re;
   logic [FW-1:0] next_im;
   logic [DW-1:0] next_sat_re;
   logic [DW-1:0] next_sat_im;

   always_comb begin
      next_re = bfr_place(link.re, lsh);
      next_im = bfr_place(link.im, lsh);
   end

   // low bits give unity gain; a wider pick is a downstream job
   // real low bits, saturated
   always_comb begin
      next_sat_re = bfr_sat(next_re);
   end

   always_comb begin
      next_sat_im = bfr_sat(next_im);
   end

   // --------------------------------------------------------------
   // strobes, one clock after link valid
   // --------------------------------------------------------------
   // strobes are never gated by the range flag
   // strobes follow valid
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         full_valid <= 1'b0;
         full_sop   <= 1'b0;
         full_eop   <= 1'b0;
      end else begin
         full_valid <= link.valid;
         full_sop   <= link.valid & link.sop;
         full_eop   <= link.valid & link.eop;
      end
   end

   // --------------------------------------------------------------
   // range flag
   // --------------------------------------------------------------
   // one pulse per offending sample; its word is still delivered
   // flag codes outside span
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         exp_err <= 1'b0;
      end else begin
         exp_err <= link.valid & ~in_range;
      end
   end

   // --------------------------------------------------------------
   // real part
   // --------------------------------------------------------------
   // held between samples, so a gap keeps the last word
   // words leave undivided, scaling downstream
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         full_re <= '0;
      end else if (link.valid) begin
         full_re <= next_re;
      end
   end

   // clipped from the placed word, not from the sample
   // saturated real word
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sat_re <= 16'h0000;
      end else if (link.valid) begin
         sat_re <= next_sat_re;
      end
   end

   // --------------------------------------------------------------
   // imaginary part
   // --------------------------------------------------------------
   // held between samples like the real word
   // imag word, same exponent
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         full_im <= '0;
      end else if (link.valid) begin
         full_im <= next_im;
      end
   end

   // same clip limits as the real part
   // saturated imag word
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sat_im <= 16'h0000;
      end else if (link.valid) begin
         sat_im <= next_sat_im;
      end
   end
endmodule // bfr_rescaler_end
`default_nettype wire

// *** verilog/bfr_pkg.sv ***
`default_nettype none
package bfr_pkg;
   // --------------------------------------------------------------
   // sizes of the worked case: 256 point quad output engine
   // --------------------------------------------------------------
   localparam int DATA_W      = 16;
   localparam int EXP_W       = 6;
   localparam int LOG2_N      = 8;
   localparam int LOG2_N_W    = 5;
   localparam int QUAD_ENGINE = 1;
   // correction and range terms
   localparam int R_EVEN      = 0;
   localparam int R_ODD       = 1;
   localparam int SINGLE_LO_K = 0;
   localparam int SINGLE_HI_K = 4;
   localparam int QUAD_LO_K   = 1;
   localparam int QUAD_HI_K   = 7;
   localparam int PASS_MUL    = 3;
   // left shift span and full scale width
   localparam int MAX_LSHIFT  = 11;
   localparam int FULL_W      = DATA_W + MAX_LSHIFT;

   // pass count: ceil(log4 N) from log2 N
   function automatic int bfr_passes(input int log2n);
      return (log2n + 1) / 2;
   endfunction

   // correction term: parity of log2 N
   function automatic int bfr_corr(input int log2n);
      return (log2n % 2 == 0) ? R_EVEN : R_ODD;
   endfunction

   // most negative legal exponent
   function automatic int bfr_exp_lo(input int log2n, input int quad);
      return -PASS_MUL * bfr_passes(log2n) + bfr_corr(log2n) + (quad != 0 ? QUAD_LO_K : SINGLE_LO_K);
   endfunction

   // most positive legal exponent
   function automatic int bfr_exp_hi(input int log2n, input int quad);
      return bfr_passes(log2n) + bfr_corr(log2n) - (quad != 0 ? QUAD_HI_K : SINGLE_HI_K);
   endfunction
endpackage
`default_nettype wire

// *** verilog/bfr_link_if.sv ***
`default_nettype none
interface bfr_link_if;
   logic                           valid;
   logic                           sop;
   logic                           eop;
   logic [bfr_pkg::DATA_W-1:0]     re;
   logic [bfr_pkg::DATA_W-1:0]     im;
   logic signed [bfr_pkg::EXP_W-1:0] expo;
   modport core (output valid, output sop, output eop, output re, output im, output expo);
   modport rescaler (input valid, input sop, input eop, input re, input im, input expo);
endinterface
`default_nettype wire

// *** verilog/bfr_core_end.sv ***
`default_nettype none
// --------------------------------------------------------------
// core end: presents samples of a block with one shared exponent
// --------------------------------------------------------------
module bfr_core_end (
   input  wire logic                              clk,
   input  wire logic                              nrst,
   bfr_link_if.core                               link,
   input  wire logic                              u_valid,
   input  wire logic                              u_sop,
   input  wire logic                              u_eop,
   input  wire logic [bfr_pkg::DATA_W-1:0]        u_re,
   input  wire logic [bfr_pkg::DATA_W-1:0]        u_im,
   input  wire logic                              u_shift_ev,
   input  wire logic                              u_shift_left
);
   localparam logic signed [bfr_pkg::EXP_W-1:0] EXP_LO =
      bfr_pkg::EXP_W'(bfr_pkg::bfr_exp_lo(bfr_pkg::LOG2_N, bfr_pkg::QUAD_ENGINE));
   localparam logic signed [bfr_pkg::EXP_W-1:0] EXP_HI =
      bfr_pkg::EXP_W'(bfr_pkg::bfr_exp_hi(bfr_pkg::LOG2_N, bfr_pkg::QUAD_ENGINE));

   logic signed [bfr_pkg::EXP_W-1:0] acc;
   logic signed [bfr_pkg::EXP_W-1:0] next_acc;
   logic signed [bfr_pkg::EXP_W-1:0] held;

   always_comb begin
      next_acc = acc;
      if (u_shift_ev) begin
         if (u_shift_left && acc > EXP_LO)
            next_acc = acc - 6'sh01;
         else if (!u_shift_left && acc < EXP_HI)
            next_acc = acc + 6'sh01;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         acc  <= 6'sh00;
         held <= 6'sh00;
      end else if (u_valid && u_sop) begin
         held <= next_acc;   // latch at block start, then restart
         acc  <= 6'sh00;
      end else begin
         acc  <= next_acc;
      end
   end

   // output stage, registered
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         link.valid <= 1'b0;
         link.sop   <= 1'b0;
         link.eop   <= 1'b0;
         link.re    <= 16'h0000;
         link.im    <= 16'h0000;
         link.expo  <= 6'sh00;
      end else begin
         link.valid <= u_valid;
         link.sop   <= u_valid & u_sop;
         link.eop   <= u_valid & u_eop;
         if (u_valid) begin
            link.re <= u_re;
            link.im <= u_im;
         end
         if (u_valid && u_sop)
            link.expo <= next_acc;
         else
            link.expo <= held;
      end
   end
endmodule // bfr_core_end
`default_nettype wire

// *** sim/bfr_link_properties.sv ***
`default_nettype none
// ------------------------
// link and output checks
// ------------------------
module bfr_link_properties (
   input wire logic              clk,
   input wire logic              nrst,
   input wire logic              valid,
   input wire logic              sop,
   input wire logic              eop,
   input wire logic [15:0]       re,
   input wire logic [15:0]       im,
   input wire logic signed [5:0] expo,
   input wire logic              full_valid,
   input wire logic              full_sop,
   input wire logic              full_eop,
   input wire logic [26:0]       full_re,
   input wire logic [26:0]       full_im,
   input wire logic              exp_err
);
   // out of range exponent falls back to no shift
   function automatic logic [26:0] place(input logic [15:0] d, input logic signed [5:0] e);
      if (e < -11 || e > -3) return {{11{d[15]}}, d};
      return {{11{d[15]}}, d} << (-e);
   endfunction
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   sop_valid_a: assert property (sop |-> valid) else $error("sop alone");
   expo_block_a: assert property ($changed(expo) |-> valid && sop) else $error("expo moved");
   expo_range_a: assert property (valid |-> expo >= -11 && expo <= 0) else $error("expo sign");
   out_follow_a: assert property (valid |=> full_valid) else $error("no output");
   out_idle_a: assert property (!valid |=> !full_valid && $stable(full_re)) else $error("idle output");
   place_re_a: assert property (valid |=> full_re == place($past(re), $past(expo))) else $error("real");
   place_im_a: assert property (valid |=> full_im == place($past(im), $past(expo))) else $error("imag");
   range_err_a: assert property (valid |=> exp_err == ($past(expo) < -11 || $past(expo) > -3))
      else $error("range flag");
   flag_follow_a: assert property (valid |=> full_sop == $past(sop) && full_eop == $past(eop))
      else $error("block flags");
endmodule // bfr_link_properties
`default_nettype wire

// *** sim/bfr_exponent_rescaler_tb_top.sv ***
`default_nettype none
// ------------------------
// rescaler bench
// ------------------------
module bfr_exponent_rescaler_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = '0, nrst = '0, u_valid = '0, u_sop = '0, u_eop = '0, u_shift_ev = '0, u_shift_left = '0;
   logic [15:0] u_re = '0, u_im = '0, sat_re, sat_im;
   logic full_valid, full_sop, full_eop, exp_err;
   logic [26:0] full_re, full_im;
   int err_count = 0, n_tests = 0;
   bfr_link_if link ();
   always #5 clk = ~clk;
   bfr_core_end bfr_core_end_inst (.clk, .nrst, .link, .u_valid, .u_sop, .u_eop, .u_re, .u_im,
      .u_shift_ev, .u_shift_left);
   bfr_rescaler_end bfr_rescaler_end_inst (.clk, .nrst, .link, .full_valid, .full_sop, .full_eop, .full_re, .full_im,
      .sat_re, .sat_im, .exp_err);
   bfr_link_properties bfr_link_properties_inst (.clk, .nrst, .valid(link.valid), .sop(link.sop), .eop(link.eop),
      .re(link.re), .im(link.im), .expo(link.expo), .full_valid, .full_sop, .full_eop, .full_re, .full_im,
      .exp_err);
   task automatic chk(input string what, input logic [26:0] e, input logic [26:0] g);
      n_tests++;
      if (g !== e) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", what, e, g);
      end
   endtask
   // expected clip of a placed word to its low 16 bits
   function automatic logic [15:0] clip(input logic [26:0] w);
      if (w[26:15] == '0 || w[26:15] == '1) return w[15:0];
      return w[26] ? 16'h8000 : 16'h7FFF;
   endfunction
   task automatic stop_test();
      $display("compares %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // one scale event per pulse, gaps keep events distinct
   task automatic shift(input int n, input logic left);
      repeat (n) begin
         @(posedge clk) #1;
         u_shift_ev = 1'h1;
         u_shift_left = left;
         @(posedge clk) #1;
         u_shift_ev = 1'h0;
      end
   endtask
   // one sample, then wait bounded for the placed word
   task automatic send(input logic [1:0] se, input logic [15:0] re, input int k, input logic err);
      logic [26:0] xr;
      logic [26:0] xi;
      xr = {{11{re[15]}}, re} << k;
      xi = {{11{~re[15]}}, ~re} << k;
      @(posedge clk) #1;
      {u_valid, u_sop, u_eop, u_re, u_im} = {1'h1, se, re, ~re};
      @(posedge clk) #1;
      {u_valid, u_sop, u_eop} = '0;
      for (int i = 0; i < 4 && full_valid !== 1'h1; i++) @(posedge clk) #1;
      if (full_valid !== 1'h1) begin
         chk("full_valid", 27'h1, 27'(full_valid));
         stop_test();
      end
      chk("full_re", xr, full_re);
      chk("full_im", xi, full_im);
      chk("sat_re", 27'(clip(xr)), 27'(sat_re));
      chk("sat_im", 27'(clip(xi)), 27'(sat_im));
      chk("full_sop", 27'(se[1]), 27'(full_sop));
      chk("full_eop", 27'(se[0]), 27'(full_eop));
      chk("exp_err", 27'(err), 27'(exp_err));
   endtask
   // first block runs at exponent zero, second at minus k
   task automatic run(input int k, input int extra, input logic [15:0] re);
      nrst = 1'h0;
      repeat (12) @(posedge clk);
      #1 nrst = 1'h1;
      send(2'h2, re, 0, 1'h1);
      shift(k + extra, 1'h1);
      shift(extra, 1'h0);
      send(2'h1, ~re, 0, 1'h1);
      send(2'h3, re, k, 1'h0);
      $display("test shift %0d done", k);
   endtask
   initial begin
      chk("full_w", 27'h00001B, 27'($bits(full_re)));
      chk("passes_64", 27'h000003, 27'(bfr_pkg::bfr_passes(6)));
      chk("corr_128", 27'h000001, 27'(bfr_pkg::bfr_corr(7)));
      chk("lo_single", -27'h00000C, 27'(bfr_pkg::bfr_exp_lo(8, 0)));
      chk("hi_single", 27'h000000, 27'(bfr_pkg::bfr_exp_hi(8, 0)));
      chk("lo_quad", -27'h00000B, 27'(bfr_pkg::bfr_exp_lo(8, 1)));
      chk("hi_quad", -27'h000003, 27'(bfr_pkg::bfr_exp_hi(8, 1)));
      $display("test exponent spans done");
      run(11, 0, 16'h8001);
      run(3, 2, 16'h7FFF);
      run(5, 2, 16'h0280);
      stop_test();
   end
endmodule // bfr_exponent_rescaler_tb_top
`default_nettype wire
